// *** src/plink_consts.svh ***
// Constants for the program linking sequencer: offsets, vector bases, reset values
`ifndef PLINK_CONSTS_SVH
`define PLINK_CONSTS_SVH

`define PL_R11_OFS      16'h0016
`define PL_R13_OFS      16'h001A
`define PL_R14_OFS      16'h001C
`define PL_R15_OFS      16'h001E
`define PL_WORD_STEP    16'h0002
`define PL_TRAP_BASE    16'h0040
`define PL_RESET_LEVEL  4'h0
`define PL_WP_RST       16'h0000
`define PL_PC_RST       16'h0000
`define PL_STATUS_RST   16'h0000

`endif

// *** src/plink_pkg.sv ***
// Types shared by the program linking sequencer and its vector address unit
package plink_pkg;
    // Linking operations accepted on the command port
    typedef enum logic [2:0] {
        OP_BRANCH,
        OP_LINK,
        OP_SWITCH,
        OP_RETURN,
        OP_TRAP
    } op_t;

    // Sequencer states
    typedef enum logic [3:0] {
        S_BOOT,
        S_IDLE,
        S_RD_WP,
        S_RD_PC,
        S_WR_R13,
        S_WR_R14,
        S_WR_R15,
        S_WR_LINK,
        S_COMMIT,
        S_RD_R13,
        S_RD_R14,
        S_RD_R15
    } state_t;

    // Source of a vector pair address
    typedef enum logic [1:0] {
        VEC_OPERAND,
        VEC_TRAP,
        VEC_LEVEL
    } vec_kind_t;
endpackage

// *** src/vector_select.sv ***
// Vector pair address unit: forms and holds the address of a two-word vector
`timescale 1ns/100ps
`include "plink_consts.svh"
module vector_select (
    input  wire logic                clk,       // Processor clock
    input  wire logic                reset_n,   // Asynchronous reset, active low
    input  wire logic                ce,        // Clock enable
    input  wire logic                load,      // Capture a new vector address
    input  wire plink_pkg::vec_kind_t kind,     // Vector source
    input  wire logic [15:0]         operand,   // Operand address of a switch
    input  wire logic [3:0]          number,    // Trap number or entry level
    output logic      [15:0]         vec_addr   // Held vector pair address
);
    import plink_pkg::*;

    logic [15:0] next_vec_addr;  // Address to capture

    // Address selection
    always_comb begin
        next_vec_addr = vec_addr;
        if (load) begin
            unique case (kind)
                VEC_OPERAND: next_vec_addr = operand;
                // Base plus four bytes per trap number
                VEC_TRAP:    next_vec_addr = `PL_TRAP_BASE + {10'h000, number, 2'b00};
                // Level zero lands on the reset pair
                VEC_LEVEL:   next_vec_addr = {10'h000, number, 2'b00};
            endcase
        end
    end

    // Address register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vec_addr <= 16'h0000;
        end else if (ce) begin
            vec_addr <= next_vec_addr;
        end
    end
endmodule

// *** src/program_linking_context_switch.sv ***
// Program linking sequencer: branch, link, context switch, return and software trap
// Behaviour
// - Branch loads target, workspace pointer kept
// - Link writes next address to link_register
// - Switch fetches vector, saves old state
// - Switch, interrupt and trap share sequence
// - Operand zero enters reset vector pair
// - Return reloads pointer, counter, status from 13-15
// - Return performs no memory write
// - Trap vectors lie at 0040 to 007F
// - Trap writes operand address to new link_register
// - Vector read as pointer then counter
// - Old pointer, counter, status into 13-15
`timescale 1ns/100ps
`include "plink_consts.svh"
module program_linking_context_switch (
    input  wire logic             clk,               // Processor clock, 25 MHz
    input  wire logic             reset_n,           // Asynchronous reset, active low
    input  wire logic             ce,                // Clock enable, freezes all state
    input  wire logic             cmd_valid,         // Linking command offered
    output logic                  cmd_ready,         // Command taken this edge
    input  wire plink_pkg::op_t   cmd_op,            // Linking operation
    input  wire logic [15:0]      cmd_target,        // Branch target or operand address
    input  wire logic             cmd_operand_is_reg, // Trap operand is a register
    input  wire logic [3:0]       cmd_reg_num,       // Register number of trap operand
    input  wire logic [3:0]       cmd_trap_num,      // Trap number
    input  wire logic [15:0]      cmd_next_pc,       // Address of following instruction
    input  wire logic             irq_valid,         // Interrupt entry requested
    input  wire logic [3:0]       irq_level,         // Interrupt level
    input  wire logic [15:0]      irq_ret_pc,        // Program counter to save on entry
    output logic                  irq_ready,         // Interrupt entry taken this edge
    input  wire logic             status_load,       // Load status word while idle
    input  wire logic [15:0]      status_in,         // New status word
    output logic                  mem_req,           // Memory cycle request
    output logic                  mem_we,            // Memory cycle is a write
    output logic      [15:0]      mem_addr,          // Memory byte address
    output logic      [15:0]      mem_wdata,         // Memory write data
    input  wire logic [15:0]      mem_rdata,         // Memory read data
    input  wire logic             mem_ack,           // Memory cycle complete
    output logic      [15:0]      wp,                // Workspace pointer
    output logic      [15:0]      pc,                // Program counter
    output logic      [15:0]      status_word,       // Status word
    output logic                  busy               // Sequence in progress
);
    import plink_pkg::*;
    state_t      state;          // Sequencer state
    state_t      next_state;
    logic [15:0] next_wp;
    logic [15:0] next_pc;
    logic [15:0] next_status;
    logic [15:0] new_wp;         // Workspace pointer being entered
    logic [15:0] next_new_wp;
    logic [15:0] new_pc;         // Program counter being entered
    logic [15:0] next_new_pc;
    logic [15:0] save_pc;        // Program counter to save in 14
    logic [15:0] next_save_pc;
    logic [15:0] link_val;       // Value written to link_register
    logic [15:0] next_link_val;
    logic        trap_mode;      // Current switch is a software trap
    logic        next_trap_mode;
    logic        vec_load;       // Capture vector address
    vec_kind_t   vec_kind;       // Vector source
    logic [3:0]  vec_number;     // Trap number or level
    logic [15:0] vec_addr;       // Held vector pair address
    logic [15:0] trap_ea;        // Resolved trap operand address

    // Register operand resolves to its place in the current workspace
    assign trap_ea = cmd_operand_is_reg ? wp + {11'h000, cmd_reg_num, 1'b0} : cmd_target;

    // Vector address unit
    vector_select u_vector_select (
        .clk      (clk),
        .reset_n  (reset_n),
        .ce       (ce),
        .load     (vec_load),
        .kind     (vec_kind),
        .operand  (cmd_target),
        .number   (vec_number),
        .vec_addr (vec_addr)
    );

    // Handshakes: interrupts win over commands when both are offered
    assign irq_ready = ce && (state == S_IDLE) && irq_valid;
    assign cmd_ready = ce && (state == S_IDLE) && !irq_valid;
    assign busy      = (state != S_IDLE);

    // Memory cycle decode from held state
    always_comb begin
        mem_req   = 1'b1;
        mem_we    = 1'b0;
        mem_addr  = 16'h0000;
        mem_wdata = 16'h0000;
        unique case (state)
            // Pointer word first, counter word next
            S_RD_WP:   mem_addr = vec_addr;
            S_RD_PC:   mem_addr = vec_addr + `PL_WORD_STEP;
            S_WR_R13: begin
                mem_we    = 1'b1;
                mem_addr  = new_wp + `PL_R13_OFS;
                mem_wdata = wp;
            end
            S_WR_R14: begin
                mem_we    = 1'b1;
                mem_addr  = new_wp + `PL_R14_OFS;
                mem_wdata = save_pc;
            end
            S_WR_R15: begin
                mem_we    = 1'b1;
                mem_addr  = new_wp + `PL_R15_OFS;
                mem_wdata = status_word;
            end
            // New workspace for a trap, current one for a link
            S_WR_LINK: begin
                mem_we    = 1'b1;
                mem_addr  = new_wp + `PL_R11_OFS;
                mem_wdata = link_val;
            end
            // Return reads only
            S_RD_R13:  mem_addr = wp + `PL_R13_OFS;
            S_RD_R14:  mem_addr = wp + `PL_R14_OFS;
            S_RD_R15:  mem_addr = wp + `PL_R15_OFS;
            default:   mem_req = 1'b0;
        endcase
    end

    // Sequencer next state
    always_comb begin
        next_state     = state;
        next_wp        = wp;
        next_pc        = pc;
        next_status    = status_word;
        next_new_wp    = new_wp;
        next_new_pc    = new_pc;
        next_save_pc   = save_pc;
        next_link_val  = link_val;
        next_trap_mode = trap_mode;
        vec_load       = 1'b0;
        vec_kind       = VEC_LEVEL;
        vec_number     = irq_level;
        unique case (state)
            // Leaving reset enters through the level zero pair
            S_BOOT: begin
                vec_load       = 1'b1;
                vec_number     = `PL_RESET_LEVEL;
                next_save_pc   = pc;
                next_trap_mode = 1'b0;
                next_state     = S_RD_WP;
            end
            S_IDLE: begin
                if (status_load) begin
                    next_status = status_in;
                end
                // Interrupt entry uses the common switch sequence
                if (irq_valid) begin
                    vec_load       = 1'b1;
                    next_save_pc   = irq_ret_pc;
                    next_trap_mode = 1'b0;
                    next_state     = S_RD_WP;
                end else if (cmd_valid) begin
                    unique case (cmd_op)
                        OP_BRANCH: next_pc = cmd_target;
                        OP_LINK: begin
                            next_new_wp   = wp;
                            next_new_pc   = cmd_target;
                            next_link_val = cmd_next_pc;
                            next_state    = S_WR_LINK;
                        end
                        OP_SWITCH: begin
                            vec_load       = 1'b1;
                            vec_kind       = VEC_OPERAND;
                            next_save_pc   = cmd_next_pc;
                            next_trap_mode = 1'b0;
                            next_state     = S_RD_WP;
                        end
                        OP_TRAP: begin
                            vec_load       = 1'b1;
                            vec_kind       = VEC_TRAP;
                            vec_number     = cmd_trap_num;
                            next_save_pc   = cmd_next_pc;
                            next_link_val  = trap_ea;
                            next_trap_mode = 1'b1;
                            next_state     = S_RD_WP;
                        end
                        OP_RETURN: next_state = S_RD_R13;
                        default:   next_state = S_IDLE;
                    endcase
                end
            end
            // Vector fetch
            S_RD_WP: if (mem_ack) begin
                next_new_wp = mem_rdata;
                next_state  = S_RD_PC;
            end
            S_RD_PC: if (mem_ack) begin
                next_new_pc = mem_rdata;
                next_state  = S_WR_R13;
            end
            // State save into the new workspace
            S_WR_R13: if (mem_ack) next_state = S_WR_R14;
            S_WR_R14: if (mem_ack) next_state = S_WR_R15;
            S_WR_R15: if (mem_ack) next_state = trap_mode ? S_WR_LINK : S_COMMIT;
            S_WR_LINK: if (mem_ack) next_state = S_COMMIT;
            // Enter the new environment
            S_COMMIT: begin
                next_wp    = new_wp;
                next_pc    = new_pc;
                next_state = S_IDLE;
            end
            // Return reload
            S_RD_R13: if (mem_ack) begin
                next_new_wp = mem_rdata;
                next_state  = S_RD_R14;
            end
            S_RD_R14: if (mem_ack) begin
                next_new_pc = mem_rdata;
                next_state  = S_RD_R15;
            end
            S_RD_R15: if (mem_ack) begin
                next_wp     = new_wp;
                next_pc     = new_pc;
                next_status = mem_rdata;
                next_state  = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end
    // Sequencer registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state       <= S_BOOT;
            wp          <= `PL_WP_RST;
            pc          <= `PL_PC_RST;
            status_word <= `PL_STATUS_RST;
            new_wp      <= 16'h0000;
            new_pc      <= 16'h0000;
            save_pc     <= 16'h0000;
            link_val    <= 16'h0000;
            trap_mode   <= 1'b0;
        end else if (ce) begin
            state       <= next_state;
            wp          <= next_wp;
            pc          <= next_pc;
            status_word <= next_status;
            new_wp      <= next_new_wp;
            new_pc      <= next_new_pc;
            save_pc     <= next_save_pc;
            link_val    <= next_link_val;
            trap_mode   <= next_trap_mode;
        end
    end
    // Checks
    sequence seq_switch_taken;
        state == S_IDLE && ce && !irq_valid && cmd_valid && cmd_op == OP_SWITCH;
    endsequence
    sequence seq_trap_taken;
        state == S_IDLE && ce && !irq_valid && cmd_valid && cmd_op == OP_TRAP;
    endsequence
    chk_branch_target: assert property (@(posedge clk) disable iff (!reset_n)
        (state == S_IDLE && ce && !irq_valid && cmd_valid && cmd_op == OP_BRANCH)
        |=> (pc == $past(cmd_target) && wp == $past(wp) && state == S_IDLE))
        else $error("branch did not load target or changed pointer");
    chk_link_write: assert property (@(posedge clk) disable iff (!reset_n)
        (state == S_IDLE && ce && !irq_valid && cmd_valid && cmd_op == OP_LINK)
        |=> (mem_we && mem_addr == wp + `PL_R11_OFS && mem_wdata == $past(cmd_next_pc)))
        else $error("link write wrong");
    chk_switch_vector: assert property (@(posedge clk) disable iff (!reset_n)
        seq_switch_taken |=> (state == S_RD_WP && mem_addr == $past(cmd_target)))
        else $error("switch vector address wrong");
    chk_irq_entry: assert property (@(posedge clk) disable iff (!reset_n)
        (state == S_IDLE && ce && irq_valid)
        |=> (state == S_RD_WP && mem_addr == {10'h000, $past(irq_level), 2'b00}))
        else $error("interrupt entry not on common sequence");
    chk_reset_pair: assert property (@(posedge clk) disable iff (!reset_n)
        (seq_switch_taken ##0 (cmd_target == 16'h0000)) |=> (mem_addr == 16'h0000))
        else $error("switch to zero missed reset pair");
    chk_return_load: assert property (@(posedge clk) disable iff (!reset_n)
        (state == S_RD_R15 && mem_ack && ce)
        |=> (wp == $past(new_wp) && status_word == $past(mem_rdata) && state == S_IDLE))
        else $error("return reload wrong");
    chk_return_nowrite: assert property (@(posedge clk) disable iff (!reset_n)
        (state == S_RD_R13 || state == S_RD_R14 || state == S_RD_R15) |-> !mem_we)
        else $error("return wrote memory");
    chk_trap_vector: assert property (@(posedge clk) disable iff (!reset_n)
        seq_trap_taken
        |=> (mem_addr == `PL_TRAP_BASE + {10'h000, $past(cmd_trap_num), 2'b00}))
        else $error("trap vector address wrong");
    chk_trap_operand: assert property (@(posedge clk) disable iff (!reset_n)
        (state == S_WR_LINK && trap_mode) |-> (mem_addr == new_wp + `PL_R11_OFS))
        else $error("trap operand not written to new link register");
    chk_vector_order: assert property (@(posedge clk) disable iff (!reset_n)
        (state == S_RD_WP && mem_ack && ce)
        |=> (state == S_RD_PC && mem_addr == $past(mem_addr) + `PL_WORD_STEP))
        else $error("vector counter word not after pointer word");
    chk_save_pointer: assert property (@(posedge clk) disable iff (!reset_n)
        (state == S_RD_PC && mem_ack && ce)
        |=> (mem_we && mem_wdata == wp && mem_addr == new_wp + `PL_R13_OFS))
        else $error("old pointer not saved");
endmodule

// *** test/plink_memory_model.sv ***
// Word memory model that answers the sequencer's memory cycles
`timescale 1ns/100ps
module plink_memory_model (
    input  wire logic        clk,       // Processor clock
    input  wire logic        reset_n,   // Reset, active low
    input  wire logic        ce,        // Cycle may complete
    input  wire logic        mem_req,   // Cycle request
    input  wire logic        mem_we,    // Write cycle
    input  wire logic [15:0] mem_addr,  // Byte address
    input  wire logic [15:0] mem_wdata, // Write data
    input  wire logic [3:0]  slow,      // Wait cycles per access
    output logic      [15:0] mem_rdata, // Read data, valid with ack
    output logic             mem_ack,   // Cycle complete
    output logic      [15:0] writes     // Writes performed
);
    logic [15:0] words [0:32767];       // Storage by word
    logic [3:0]  cnt;                   // Wait counter
    // Ack stays up until the sequencer takes it; data scrambled otherwise
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_ack <= 1'b0;
            cnt <= 4'h0;
            writes <= 16'h0000;
            mem_rdata <= 16'h5A5A;
        end else if (mem_ack) begin
            if (ce) begin
                mem_ack <= 1'b0;
                mem_rdata <= ~mem_rdata;
                cnt <= 4'h0;
                if (mem_we) begin
                    words[mem_addr[15:1]] <= mem_wdata;
                    writes <= writes + 16'h0001;
                end
            end
        end else if (mem_req) begin
            if (cnt >= slow) begin
                mem_ack <= 1'b1;
                if (!mem_we) mem_rdata <= words[mem_addr[15:1]];
            end else cnt <= cnt + 4'h1;
        end
    end
endmodule

// *** test/program_linking_context_switch_tb.sv ***
// Self-checking bench for the program linking sequencer
`timescale 1ns/100ps
module program_linking_context_switch_tb;
    import plink_pkg::*;
    logic        clk = 1'b0;           // 25 MHz clock
    logic        reset_n = 1'b0;       // Reset, active low
    logic        ce = 1'b1;            // Clock enable
    logic        cmd_valid = 1'b0;     // Command offered
    logic        cmd_ready;            // Command taken
    op_t         cmd_op = OP_BRANCH;   // Operation
    logic [15:0] cmd_target = 16'h0000; // Target or operand
    logic        cmd_is_reg = 1'b0;    // Trap operand is register
    logic [3:0]  cmd_num = 4'h0;       // Trap and register number
    logic [15:0] cmd_next_pc = 16'h0000; // Following address
    logic        irq_valid = 1'b0;     // Interrupt request
    logic [3:0]  irq_level = 4'h0;     // Interrupt level
    logic [15:0] irq_ret_pc = 16'h0000; // Saved counter
    logic        irq_ready;            // Interrupt taken
    logic        status_load = 1'b0;   // Status load strobe
    logic [15:0] status_in = 16'h0000; // New status
    logic        mem_req;              // Memory request
    logic        mem_we;               // Memory write
    logic [15:0] mem_addr;             // Memory address
    logic [15:0] mem_wdata;            // Write data
    logic [15:0] mem_rdata;            // Read data
    logic        mem_ack;              // Memory ack
    logic [15:0] wp;                   // Workspace pointer
    logic [15:0] pc;                   // Program counter
    logic [15:0] status_word;          // Status
    logic        busy;                 // Sequence running
    logic [3:0]  slow = 4'h0;          // Memory wait cycles
    logic [15:0] writes;               // Memory write count
    logic [15:0] ewp;                  // Expected pointer
    logic [15:0] epc;                  // Expected counter
    logic [15:0] est;                  // Expected status
    int          fail_count = 0;       // Mismatches
    int          total_checks = 0;     // Comparisons

    always #20 clk = ~clk;

    program_linking_context_switch DUT (.clk(clk), .reset_n(reset_n), .ce(ce),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
        .cmd_target(cmd_target), .cmd_operand_is_reg(cmd_is_reg), .cmd_reg_num(cmd_num),
        .cmd_trap_num(cmd_num), .cmd_next_pc(cmd_next_pc), .irq_valid(irq_valid),
        .irq_level(irq_level), .irq_ret_pc(irq_ret_pc), .irq_ready(irq_ready),
        .status_load(status_load), .status_in(status_in), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .wp(wp), .pc(pc),
        .status_word(status_word), .busy(busy));

    plink_memory_model mem_model (.clk(clk), .reset_n(reset_n), .ce(ce),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .slow(slow), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .writes(writes));

    function automatic logic [15:0] rd(input logic [15:0] a);
        return mem_model.words[a[15:1]];
    endfunction

    task automatic put(input logic [15:0] a, input logic [15:0] d);
        mem_model.words[a[15:1]] = d;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // Bounded wait step; running out ends the run
    task automatic bound(inout int n);
        n++;
        if (n > 400) begin
            fail_count++;
            $display("MISMATCH wait expected done seen stuck");
            report_and_stop();
        end
    endtask

    task automatic state_is(input string s, input logic [15:0] w, p, t);
        check({s, " wp"}, wp, w);
        check({s, " pc"}, pc, p);
        check({s, " status"}, status_word, t);
    endtask

    // Saved pointer, counter and status in the new workspace
    task automatic saved(input logic [15:0] nw, ow, op, os);
        check("saved wp", rd(nw + 16'h001A), ow);
        check("saved pc", rd(nw + 16'h001C), op);
        check("saved status", rd(nw + 16'h001E), os);
    endtask

    task automatic load_status(input logic [15:0] v);
        tick();
        status_in = v;
        status_load = 1'b1;
        tick();
        status_load = 1'b0;
        check("status load", status_word, v);
    endtask

    // Offer one command, optionally freeze mid-sequence, wait for idle
    task automatic issue(input op_t op, input logic [15:0] t, input logic [15:0] np,
                         input logic r, input logic [3:0] tn, input logic pause);
        int n;
        n = 0;
        tick();
        cmd_op = op;
        cmd_target = t;
        cmd_next_pc = np;
        cmd_is_reg = r;
        cmd_num = tn;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) begin tick(); bound(n); end
        tick();
        cmd_valid = 1'b0;
        if (pause) begin
            ce = 1'b0;
            repeat (6) tick();
            check("frozen busy", {15'h0000, busy}, 16'h0001);
            check("frozen wp", wp, ewp);
            ce = 1'b1;
        end
        while (busy !== 1'b0) begin tick(); bound(n); end
    endtask

    task automatic t_branch();
        int n;
        n = 0;
        tick();
        cmd_op = OP_BRANCH;
        cmd_target = 16'h1234;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) begin tick(); bound(n); end
        tick();
        cmd_target = 16'h1240;
        check("branch pc", pc, 16'h1234);
        tick();
        cmd_valid = 1'b0;
        state_is("branch", ewp, 16'h1240, est);
        check("branch busy", {15'h0000, busy}, 16'h0000);
        epc = 16'h1240;
        $display("Test branch done");
    endtask

    task automatic t_traps();
        logic [15:0] nw;
        logic [15:0] opa;
        for (int i = 0; i < 16; i++) begin
            nw = 16'h0800 + (16'(i) << 5);
            put(16'h0040 + (16'(i) << 2), nw);
            put(16'h0042 + (16'(i) << 2), 16'h4000 + 16'(i));
            opa = i[0] ? ewp + (16'(i) << 1) : 16'h1230 + 16'(i);
            issue(OP_TRAP, 16'h1230 + 16'(i), 16'h3100 + 16'(i), i[0], i[3:0], 1'b0);
            state_is("trap", nw, 16'h4000 + 16'(i), est);
            saved(nw, ewp, 16'h3100 + 16'(i), est);
            check("trap operand", rd(nw + 16'h0016), opa);
            ewp = nw;
            epc = 16'h4000 + 16'(i);
        end
        $display("Test traps done");
    endtask

    task automatic t_irq();
        int n;
        n = 0;
        put(16'h0014, 16'h0A00);
        put(16'h0016, 16'h5000);
        tick();
        irq_level = 4'h5;
        irq_ret_pc = 16'h6000;
        irq_valid = 1'b1;
        #1;
        check("ready under irq", {15'h0000, cmd_ready}, 16'h0000);
        while (irq_ready !== 1'b1) begin tick(); bound(n); end
        tick();
        irq_valid = 1'b0;
        while (busy !== 1'b0) begin tick(); bound(n); end
        state_is("irq", 16'h0A00, 16'h5000, est);
        saved(16'h0A00, ewp, 16'h6000, est);
        $display("Test interrupt done");
    endtask

    initial begin
        put(16'h0000, 16'h0100);
        put(16'h0002, 16'h0200);
        repeat (20) @(posedge clk);
        #1;
        reset_n = 1'b1;
        issue(OP_BRANCH, 16'h0200, 16'h0000, 1'b0, 4'h0, 1'b0);
        state_is("boot", 16'h0100, 16'h0200, 16'h0000);
        saved(16'h0100, 16'h0000, 16'h0000, 16'h0000);
        ewp = 16'h0100;
        epc = 16'h0200;
        est = 16'h0000;
        $display("Test boot done");
        t_branch();
        issue(OP_LINK, 16'h2000, 16'h1002, 1'b0, 4'h0, 1'b0);
        check("link word", rd(ewp + 16'h0016), 16'h1002);
        state_is("link", ewp, 16'h2000, est);
        $display("Test link done");
        load_status(16'hA5C3);
        est = 16'hA5C3;
        put(16'h0300, 16'h0400);
        put(16'h0302, 16'h3000);
        slow = 4'h3;
        issue(OP_SWITCH, 16'h0300, 16'h2006, 1'b0, 4'h0, 1'b1);
        slow = 4'h0;
        state_is("switch", 16'h0400, 16'h3000, est);
        saved(16'h0400, ewp, 16'h2006, est);
        $display("Test switch done");
        load_status(16'h0F0F);
        put(16'h0000, 16'h0100);
        issue(OP_RETURN, 16'h0000, 16'h0000, 1'b0, 4'h0, 1'b0);
        state_is("return", 16'h0100, 16'h2006, 16'hA5C3);
        // Boot three, link one, switch three; the return adds none
        check("return writes", writes, 16'h0007);
        $display("Test return done");
        issue(OP_SWITCH, 16'h0000, 16'h2008, 1'b0, 4'h0, 1'b0);
        state_is("zero vector", 16'h0100, 16'h0200, est);
        saved(16'h0100, 16'h0100, 16'h2008, est);
        $display("Test zero vector done");
        ewp = 16'h0100;
        epc = 16'h0200;
        t_traps();
        t_irq();
        report_and_stop();
    end
endmodule
